/* pcl_loader.v */
// pin-program configuration loader with serial register ports
`include "pcl_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pcl_loader #(
  parameter [7:0] SIL_REV = 8'h5A, // arbitrary value
  parameter [15:0] FAMILY_ID = 16'h3C7E, // arbitrary value
  parameter [6:0] I2C_DEV_ADDR = 7'h48 // bus address of this device
) (
  input wire ref_clk, // 50 MHz clock
  input wire sys_rst, // sync reset, active high
  input wire strap_mode_select_pin, // high = hard mode
  input wire [1:0] multifunction_pin_0, // three-level code
  input wire [1:0] multifunction_pin_1, // three-level code
  input wire [1:0] multifunction_pin_2, // three-level code
  input wire [1:0] multifunction_pin_3, // three-level code
  input wire [1:0] multifunction_pin_4, // three-level code
  input wire [1:0] multifunction_pin_5, // three-level code
  input wire [1:0] irq_pin_level, // three-level code of irq pin
  input wire spi_cs_n, // spi chip select
  input wire spi_sclk, // spi clock
  input wire spi_sdio_i, // spi data in
  output reg spi_sdio_o, // spi data out, 3-wire
  output wire spi_sdio_oe, // drive enable of sdio
  output reg spi_sdo_o, // spi data out, 4-wire
  output wire spi_sdo_oe, // drive enable of sdo
  input wire i2c_scl, // i2c clock
  input wire i2c_sda_i, // i2c data in
  output wire i2c_sda_o, // always low when driven
  output wire i2c_sda_oe, // pulls sda low
  input wire nv_load_we, // store load write strobe
  input wire [12:0] nv_load_addr, // store load address
  input wire [7:0] nv_load_data, // store load data
  output reg hard_mode, // strap mode in force
  output reg [3:0] input_freq_id, // input frequency id
  output reg [3:0] output_freq_id, // output frequency id
  output reg [1:0] sysclk_cfg, // sysclk config id
  output reg crystal_input_mode, // crystal drive on
  output reg sysclk_doubler_en, // doubler on
  output reg [7:0] sysclk_n_div, // sysclk N divide
  output reg [1:0] freq_tolerance_sel, // tolerance range
  output reg [1:0] loop_bw_sel, // loop bandwidth
  output reg phase_margin_high, // high phase margin
  output reg [19:0] ref_scale_factor, // ref d..a factors, 5 bits each
  output reg [19:0] chan_scale_factor // ch 3..0 factors, 5 bits each
);

  // base-3 value of three pins, clamped to 15
  function [3:0] tl_id;
    input [1:0] hi;
    input [1:0] mi;
    input [1:0] lo;
    reg [5:0] v;
    begin
      v = 6'd9 * {4'd0, hi} + 6'd3 * {4'd0, mi} + {4'd0, lo};
      tl_id = (v > 6'd15) ? 4'hF : v[3:0];
    end
  endfunction

  // two-bit code to divide factor
  function [4:0] scale_of;
    input [1:0] c;
    begin
      case (c)
        2'd0: scale_of = 5'd1;
        2'd1: scale_of = 5'd4;
        2'd2: scale_of = 5'd8;
        default: scale_of = 5'd16;
      endcase
    end
  endfunction

  // pin synchronisers: straps, spi, i2c
  reg [14:0] pin_s1_q;
  reg [14:0] pin_s2_q;
  reg [4:0] ser_s1_q;
  reg [4:0] ser_s2_q;
  reg [4:0] ser_d_q;
  always @(posedge ref_clk) begin
    pin_s1_q <= {strap_mode_select_pin, multifunction_pin_5, multifunction_pin_4, multifunction_pin_3,
                 multifunction_pin_2, multifunction_pin_1, multifunction_pin_0, irq_pin_level};
    pin_s2_q <= pin_s1_q;
    ser_s1_q <= {spi_cs_n, spi_sclk, spi_sdio_i, i2c_scl, i2c_sda_i};
    ser_s2_q <= ser_s1_q;
    ser_d_q <= ser_s2_q;
  end
  wire cs_n = ser_s2_q[4];
  wire sclk_rise = ser_s2_q[3] & ~ser_d_q[3];
  wire sclk_fall = ~ser_s2_q[3] & ser_d_q[3];
  wire sdio = ser_s2_q[2];
  wire scl_rise = ser_s2_q[1] & ~ser_d_q[1];
  wire scl_fall = ~ser_s2_q[1] & ser_d_q[1];
  wire sda = ser_s2_q[0];
  wire i2c_start = ser_s2_q[1] & ser_d_q[1] & ~sda & ser_d_q[0];
  wire i2c_stop = ser_s2_q[1] & ser_d_q[1] & sda & ~ser_d_q[0];

  // strap capture once after each sys_rst release
  reg [1:0] settle_q;
  reg strap_done_q;
  reg [3:0] hw_in_q;
  reg [3:0] hw_out_q;
  reg [1:0] hw_sys_q;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      settle_q <= 2'd0;
      strap_done_q <= 1'b0;
      hard_mode <= 1'b0;
      hw_in_q <= 4'h0;
      hw_out_q <= 4'h0;
      hw_sys_q <= 2'd0;
    end else if (!strap_done_q) begin
      if (settle_q == `PCL_STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        hard_mode <= pin_s2_q[14];
        hw_in_q <= tl_id(pin_s2_q[13:12], pin_s2_q[11:10], pin_s2_q[3:2]);
        hw_out_q <= tl_id(pin_s2_q[9:8], pin_s2_q[7:6], pin_s2_q[5:4]);
        hw_sys_q <= (pin_s2_q[1:0] == `PCL_TL_HIGH) ? 2'd2 :
                    (pin_s2_q[1:0] == `PCL_TL_MID) ? 2'd1 : 2'd0;
      end else begin
        settle_q <= settle_q + 2'd1;
      end
    end
  end

  // register storage
  reg [7:0] port_ctrl_q;
  reg [7:0] scr_lo_q;
  reg [7:0] scr_hi_q;
  reg update_q;
  reg [7:0] buf_q [0:7];
  reg [7:0] act_q [0:7];

  // shared write port, spi wins a same-cycle clash
  wire spi_we;
  wire i2c_we;
  wire [12:0] spi_addr;
  wire [12:0] i2c_addr;
  wire [7:0] spi_wdata;
  wire [7:0] i2c_wdata;
  wire host_we = spi_we | i2c_we;
  wire [12:0] wr_addr = spi_we ? spi_addr : i2c_addr;
  wire [7:0] wr_data = spi_we ? spi_wdata : i2c_wdata;

  // map an address to a buffered slot
  reg slot_hit;
  reg [2:0] slot;
  reg slot_open;
  always @* begin
    slot_hit = 1'b1;
    slot = `PCL_I_RB;
    if (wr_addr == `PCL_A_RB_CTRL) begin
      slot = `PCL_I_RB;
    end else if (wr_addr == `PCL_A_S1_EN) begin
      slot = `PCL_I_S1;
    end else if (wr_addr == `PCL_A_FSEL) begin
      slot = `PCL_I_FSEL;
    end else if (wr_addr == `PCL_A_SCSEL) begin
      slot = `PCL_I_SCSEL;
    end else if (wr_addr == `PCL_A_S2_EN) begin
      slot = `PCL_I_S2;
    end else if (wr_addr == `PCL_A_IN_SCALE) begin
      slot = `PCL_I_INSC;
    end else if (wr_addr == `PCL_A_OUT_SCALE) begin
      slot = `PCL_I_OUTSC;
    end else if (wr_addr == `PCL_A_TUNE) begin
      slot = `PCL_I_TUNE;
    end else begin
      slot_hit = 1'b0;
    end
    if (slot == `PCL_I_FSEL || slot == `PCL_I_SCSEL) begin
      slot_open = buf_q[`PCL_I_S1][`PCL_B_SEC_EN];
    end else if (slot == `PCL_I_INSC || slot == `PCL_I_OUTSC || slot == `PCL_I_TUNE) begin
      slot_open = buf_q[`PCL_I_S2][`PCL_B_SEC_EN];
    end else begin
      slot_open = 1'b1;
    end
  end

  // store load slot decode, port control excluded
  reg nv_hit;
  reg [2:0] nv_slot;
  always @* begin
    nv_hit = 1'b1;
    nv_slot = 3'd0;
    if (nv_load_addr == `PCL_A_RB_CTRL) begin
      nv_slot = `PCL_I_RB;
    end else if (nv_load_addr >= `PCL_A_S1_EN && nv_load_addr <= `PCL_A_TUNE) begin
      nv_slot = nv_load_addr[2:0] + 3'd1;
    end else begin
      nv_hit = 1'b0;
    end
  end

  wire soft_rst = host_we && wr_addr == `PCL_A_PORT_CTRL && wr_data[`PCL_B_SOFT_RST];
  integer i;
  // register writes, update copy and soft reset
  always @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      port_ctrl_q <= `PCL_RST_BYTE;
      scr_lo_q <= `PCL_RST_BYTE;
      scr_hi_q <= `PCL_RST_BYTE;
      update_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        buf_q[i] <= `PCL_RST_BYTE;
        act_q[i] <= `PCL_RST_BYTE;
      end
    end else begin
      update_q <= 1'b0;
      if (update_q) begin
        for (i = 0; i < 8; i = i + 1) begin
          act_q[i] <= buf_q[i];
        end
      end
      if (nv_load_we && nv_hit) begin
        buf_q[nv_slot] <= nv_load_data;
      end
      if (host_we) begin
        if (wr_addr == `PCL_A_PORT_CTRL) begin
          port_ctrl_q <= {wr_data[7:6], 6'd0};
        end else if (wr_addr == `PCL_A_UPDATE) begin
          update_q <= wr_data[`PCL_B_UPDATE];
        end else if (wr_addr == `PCL_A_SCR_LO) begin
          scr_lo_q <= wr_data;
        end else if (wr_addr == `PCL_A_SCR_HI) begin
          scr_hi_q <= wr_data;
        end else if (slot_hit && slot_open) begin
          buf_q[slot] <= wr_data;
        end
      end
    end
  end

  // read mux, active or buffered copy per readback select
  function [7:0] rd_byte;
    input [12:0] a;
    input sel_buf;
    reg [7:0] v;
    begin
      v = 8'h00;
      if (a == `PCL_A_PORT_CTRL) begin
        v = port_ctrl_q;
      end else if (a == `PCL_A_UPDATE) begin
        v = {7'd0, update_q};
      end else if (a == `PCL_A_SCR_LO) begin
        v = scr_lo_q;
      end else if (a == `PCL_A_SCR_HI) begin
        v = scr_hi_q;
      end else if (a == `PCL_A_SIL_REV) begin
        v = SIL_REV;
      end else if (a == `PCL_A_RSVD_B) begin
        v = `PCL_RST_RSVD_B;
      end else if (a == `PCL_A_FAM_LO) begin
        v = FAMILY_ID[7:0];
      end else if (a == `PCL_A_FAM_HI) begin
        v = FAMILY_ID[15:8];
      end else if (a == `PCL_A_RB_CTRL) begin
        v = sel_buf ? buf_q[`PCL_I_RB] : act_q[`PCL_I_RB];
      end else if (a >= `PCL_A_S1_EN && a <= `PCL_A_TUNE) begin
        v = sel_buf ? buf_q[a[2:0] + 3'd1] : act_q[a[2:0] + 3'd1];
      end
      rd_byte = v;
    end
  endfunction
  wire rb_buf = act_q[`PCL_I_RB][`PCL_B_RB_BUF];

  // spi slave: 16-bit instruction then data bytes, address steps up
  reg [4:0] spi_cnt_q;
  reg [15:0] spi_sh_q;
  reg spi_rd_q;
  reg [12:0] spi_addr_q;
  reg [7:0] spi_tx_q;
  reg spi_we_q;
  reg [7:0] spi_wd_q;
  always @(posedge ref_clk) begin
    spi_we_q <= 1'b0;
    if (sys_rst || cs_n) begin
      spi_cnt_q <= 5'd0;
      spi_sh_q <= 16'h0000;
      spi_rd_q <= 1'b0;
      spi_addr_q <= 13'h0000;
      spi_tx_q <= 8'h00;
      spi_wd_q <= 8'h00;
      spi_sdio_o <= 1'b0;
      spi_sdo_o <= 1'b0;
    end else if (sclk_rise) begin
      spi_sh_q <= {spi_sh_q[14:0], sdio};
      if (spi_cnt_q == 5'd15) begin
        spi_rd_q <= spi_sh_q[14];
        spi_addr_q <= {spi_sh_q[11:0], sdio};
        spi_tx_q <= rd_byte({spi_sh_q[11:0], sdio}, rb_buf);
        spi_cnt_q <= 5'd16;
      end else if (spi_cnt_q == 5'd23) begin
        spi_we_q <= ~spi_rd_q;
        spi_wd_q <= {spi_sh_q[6:0], sdio};
        spi_addr_q <= spi_addr_q + 13'd1;
        spi_tx_q <= rd_byte(spi_addr_q + 13'd1, rb_buf);
        spi_cnt_q <= 5'd16;
      end else begin
        spi_cnt_q <= spi_cnt_q + 5'd1;
      end
    end else if (sclk_fall && spi_cnt_q >= 5'd16) begin
      spi_sdio_o <= spi_tx_q[7];
      spi_sdo_o <= spi_tx_q[7];
      spi_tx_q <= {spi_tx_q[6:0], 1'b0};
    end
  end
  // a byte write lands the cycle after its last clock rise
  assign spi_we = spi_we_q;
  assign spi_addr = spi_addr_q - 13'd1;
  assign spi_wdata = spi_wd_q;
  wire spi_drive = ~cs_n & spi_rd_q & (spi_cnt_q >= 5'd16);
  assign spi_sdio_oe = spi_drive & ~port_ctrl_q[`PCL_B_SDO_EN];
  assign spi_sdo_oe = spi_drive & port_ctrl_q[`PCL_B_SDO_EN];

  // i2c slave states
  localparam [2:0] IS_IDLE = 3'd0;
  localparam [2:0] IS_RX = 3'd1;
  localparam [2:0] IS_ACK = 3'd2;
  localparam [2:0] IS_TX = 3'd3;
  localparam [2:0] IS_MACK = 3'd4;
  reg [2:0] i_st_q;
  reg [3:0] i_cnt_q;
  reg [7:0] i_sh_q;
  reg [1:0] i_byte_q;
  reg i_rw_q;
  reg [12:0] i_addr_q;
  reg [7:0] i_tx_q;
  reg i_we_q;
  reg [7:0] i_wd_q;
  reg [12:0] i_wa_q;
  always @(posedge ref_clk) begin
    i_we_q <= 1'b0;
    if (sys_rst || i2c_stop) begin
      i_st_q <= IS_IDLE;
      i_cnt_q <= 4'd0;
      i_sh_q <= 8'h00;
      i_byte_q <= 2'd0;
      i_rw_q <= 1'b0;
      i_tx_q <= 8'h00;
      i_wd_q <= 8'h00;
      i_wa_q <= 13'h0000;
      if (sys_rst) begin
        i_addr_q <= 13'h0000;
      end
    end else if (i2c_start) begin
      i_st_q <= hard_mode ? IS_IDLE : IS_RX;
      i_cnt_q <= 4'd0;
      i_byte_q <= 2'd0;
    end else begin
      case (i_st_q)
        IS_RX: begin
          if (scl_rise) begin
            i_sh_q <= {i_sh_q[6:0], sda};
            i_cnt_q <= i_cnt_q + 4'd1;
          end else if (scl_fall && i_cnt_q == 4'd8) begin
            i_st_q <= IS_ACK;
            if (i_byte_q == 2'd0) begin
              i_rw_q <= i_sh_q[0];
              if (i_sh_q[7:1] != I2C_DEV_ADDR) begin
                i_st_q <= IS_IDLE;
              end
            end else if (i_byte_q == 2'd1) begin
              i_addr_q[12:8] <= i_sh_q[4:0];
            end else if (i_byte_q == 2'd2) begin
              i_addr_q[7:0] <= i_sh_q;
            end else begin
              i_we_q <= 1'b1;
              i_wd_q <= i_sh_q;
              i_wa_q <= i_addr_q;
              i_addr_q <= i_addr_q + 13'd1;
            end
          end
        end
        IS_ACK: begin
          if (scl_fall) begin
            i_cnt_q <= 4'd0;
            if (i_byte_q != 2'd3) begin
              i_byte_q <= i_byte_q + 2'd1;
            end
            if (i_rw_q && i_byte_q == 2'd0) begin
              i_st_q <= IS_TX;
              i_tx_q <= rd_byte(i_addr_q, rb_buf);
              i_addr_q <= i_addr_q + 13'd1;
            end else begin
              i_st_q <= IS_RX;
            end
          end
        end
        IS_TX: begin
          if (scl_fall) begin
            i_tx_q <= {i_tx_q[6:0], 1'b0};
            i_cnt_q <= i_cnt_q + 4'd1;
            if (i_cnt_q == 4'd7) begin
              i_st_q <= IS_MACK;
            end
          end
        end
        IS_MACK: begin
          if (scl_rise && sda) begin
            i_st_q <= IS_IDLE;
          end else if (scl_fall) begin
            i_st_q <= IS_TX;
            i_cnt_q <= 4'd0;
            i_tx_q <= rd_byte(i_addr_q, rb_buf);
            i_addr_q <= i_addr_q + 13'd1;
          end
        end
        default: begin
          i_st_q <= IS_IDLE;
        end
      endcase
    end
  end
  assign i2c_we = i_we_q;
  assign i2c_addr = i_wa_q;
  assign i2c_wdata = i_wd_q;
  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe = (i_st_q == IS_ACK) | (i_st_q == IS_TX & ~i_tx_q[7]);

  // registered configuration outputs
  wire soft_s1 = act_q[`PCL_I_S1][`PCL_B_SEC_EN];
  wire soft_s2 = act_q[`PCL_I_S2][`PCL_B_SEC_EN];
  wire [7:0] fsel = act_q[`PCL_I_FSEL];
  wire [7:0] insc = act_q[`PCL_I_INSC];
  wire [7:0] outsc = act_q[`PCL_I_OUTSC];
  wire [7:0] tune = act_q[`PCL_I_TUNE];
  reg [1:0] cfg_d;
  integer k;
  always @* begin
    // soft bits stand in for straps
    if (hard_mode) begin
      cfg_d = hw_sys_q;
    end else if (soft_s1) begin
      cfg_d = act_q[`PCL_I_SCSEL][1:0];
    end else begin
      cfg_d = 2'd0;
    end
  end
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      input_freq_id <= 4'h0;
      output_freq_id <= 4'h0;
      sysclk_cfg <= 2'd0;
      crystal_input_mode <= 1'b1;
      sysclk_doubler_en <= 1'b1;
      sysclk_n_div <= `PCL_N_DIV8;
      freq_tolerance_sel <= 2'd0;
      loop_bw_sel <= 2'd0;
      phase_margin_high <= 1'b0;
      ref_scale_factor <= {4{5'd1}};
      chan_scale_factor <= {4{5'd1}};
    end else begin
      input_freq_id <= hard_mode ? hw_in_q : (soft_s1 ? fsel[3:0] : 4'h0);
      output_freq_id <= hard_mode ? hw_out_q : (soft_s1 ? fsel[7:4] : 4'h0);
      sysclk_cfg <= cfg_d;
      crystal_input_mode <= (cfg_d == 2'd0) || (cfg_d == 2'd2);
      sysclk_doubler_en <= (cfg_d != 2'd3);
      sysclk_n_div <= (cfg_d == 2'd2) ? `PCL_N_DIV16 : `PCL_N_DIV8;
      freq_tolerance_sel <= soft_s2 ? tune[1:0] : 2'd0;
      loop_bw_sel <= soft_s2 ? tune[3:2] : 2'd0;
      phase_margin_high <= soft_s2 & tune[`PCL_B_PM];
      for (k = 0; k < 4; k = k + 1) begin
        ref_scale_factor[k * 5 +: 5] <= (soft_s2 & ~hard_mode) ? scale_of(insc[k * 2 +: 2]) : 5'd1;
        chan_scale_factor[k * 5 +: 5] <= (soft_s2 & ~hard_mode) ? scale_of(outsc[k * 2 +: 2]) : 5'd1;
      end
    end
  end

endmodule
`default_nettype wire

/* pcl_loader_asserts.sv */
// port checker for the config loader
`timescale 1ns/1ps
`default_nettype none
module pcl_loader_asserts (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic i2c_sda_oe, // sda pull
  input wire logic hard_mode, // strap mode
  input wire logic [3:0] input_freq_id, // in id
  input wire logic [3:0] output_freq_id, // out id
  input wire logic [1:0] sysclk_cfg, // cfg id
  input wire logic crystal_input_mode, // crystal_input_mode
  input wire logic sysclk_doubler_en, // doubler
  input wire logic [7:0] sysclk_n_div, // n divide
  input wire logic [19:0] ref_scale_factor, // ref factors
  input wire logic [19:0] chan_scale_factor // chan factors
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // each 5-bit factor must be 1, 4, 8 or 16
  function automatic logic legal(input logic [19:0] f);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ok = ok & (f[i*5+:5] inside {5'h01, 5'h04, 5'h08, 5'h10});
    end
    return ok;
  endfunction
  // sysclk fields track the config id
  chk_crystal_input_mode_map: assert property (
    crystal_input_mode == (sysclk_cfg == 2'h0 || sysclk_cfg == 2'h2)) else $error("crystal_input_mode mode wrong");
  chk_ndiv_map: assert property (
    sysclk_n_div == ((sysclk_cfg == 2'h2) ? 8'h10 : 8'h08)) else $error("n divide wrong");
  chk_dbl_map: assert property (
    sysclk_doubler_en == (sysclk_cfg != 2'h3)) else $error("doubler wrong");
  // strap mode behaviour, then scale factor range
  chk_hard_cfg: assert property (
    hard_mode |-> sysclk_cfg != 2'h3) else $error("cfg 3 in hard mode");
  chk_mode_hold: assert property (
    $past(hard_mode) |-> hard_mode) else $error("hard mode dropped");
  chk_ids_hold: assert property (
    $past(hard_mode, 3) && hard_mode |-> $stable({input_freq_id, output_freq_id, sysclk_cfg}))
    else $error("strap ids moved");
  chk_i2c_quiet: assert property (
    hard_mode |-> !i2c_sda_oe) else $error("i2c active in hard mode");
  chk_scale_legal: assert property (
    legal(ref_scale_factor) && legal(chan_scale_factor)) else $error("bad scale factor");
  // main scenarios
  cover property (hard_mode && sysclk_cfg == 2'h2);
  cover property (sysclk_cfg == 2'h3);
  cover property (ref_scale_factor[4:0] == 5'h04);
endmodule
`default_nettype wire

/* pcl_loader_tb_top.sv */
// self-checking bench for the config loader
`timescale 1ns/1ps
`default_nettype none
module pcl_loader_tb_top;
  logic ref_clk, sys_rst, pin_mode, spi_cs_n, spi_sclk, spi_sdio_i, spi_sdio_o, spi_sdio_oe;
  logic hard_mode, crystal_input_mode, sysclk_doubler_en, phase_margin_high;
  logic [11:0] straps;
  logic [1:0] irq_lvl, sysclk_cfg, freq_tolerance_sel, loop_bw_sel;
  logic [3:0] input_freq_id, output_freq_id;
  logic [7:0] sysclk_n_div, rq;
  logic [19:0] ref_scale_factor, chan_scale_factor;
  int num_errors, compares;
  logic nv_we, i2c_scl, i2c_sda_h, i2c_sda_oe;
  logic [12:0] nv_addr;
  logic [7:0] nv_data;
  logic [3:0] ak;
  wire logic i2c_sda = i2c_sda_h & ~i2c_sda_oe;
  wire logic [20:0] cfg_vec = {hard_mode, input_freq_id, output_freq_id, sysclk_cfg,
    crystal_input_mode, sysclk_doubler_en, sysclk_n_div};
  wire logic [44:0] tune_vec = {freq_tolerance_sel, loop_bw_sel, phase_margin_high,
    ref_scale_factor, chan_scale_factor};
  localparam logic [44:0] TUNE_DEF = {5'h00, 20'h0_8421, 20'h0_8421};
  // id parameters are arbitrary values
  pcl_loader #(.SIL_REV(8'h3D), .FAMILY_ID(16'h6B19)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .strap_mode_select_pin(pin_mode),
    .multifunction_pin_0(straps[1:0]), .multifunction_pin_1(straps[3:2]), .multifunction_pin_2(straps[5:4]),
    .multifunction_pin_3(straps[7:6]), .multifunction_pin_4(straps[9:8]), .multifunction_pin_5(straps[11:10]),
    .irq_pin_level(irq_lvl), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdio_i(spi_sdio_i),
    .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe), .spi_sdo_o(), .spi_sdo_oe(),
    .i2c_scl(i2c_scl), .i2c_sda_i(i2c_sda), .i2c_sda_o(), .i2c_sda_oe(i2c_sda_oe),
    .nv_load_we(nv_we), .nv_load_addr(nv_addr), .nv_load_data(nv_data),
    .hard_mode(hard_mode), .input_freq_id(input_freq_id), .output_freq_id(output_freq_id),
    .sysclk_cfg(sysclk_cfg), .crystal_input_mode(crystal_input_mode), .sysclk_doubler_en(sysclk_doubler_en),
    .sysclk_n_div(sysclk_n_div), .freq_tolerance_sel(freq_tolerance_sel), .loop_bw_sel(loop_bw_sel),
    .phase_margin_high(phase_margin_high), .ref_scale_factor(ref_scale_factor),
    .chan_scale_factor(chan_scale_factor));
  pcl_spi_host host (.ref_clk(ref_clk), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdio_i(spi_sdio_i));
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // comparisons
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [44:0] got, input logic [44:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register access
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rq);
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, rq);
    chk_reg(rq, exp);
  endtask
  // i2c one-byte write, acks caught in ak, msb is device address ack
  task automatic i2c_wr(input logic [12:0] a, input logic [7:0] d);
    logic [31:0] sh;
    sh = {8'h90, 3'b000, a, d};
    ak = 4'h0;
    i2c_sda_h = 1'b0;
    repeat (4) @(negedge ref_clk);
    i2c_scl = 1'b0;
    for (int b = 3; b >= 0; b--) begin
      for (int i = 8; i >= 0; i--) begin
        repeat (2) @(negedge ref_clk);
        i2c_sda_h = (i > 0) ? sh[b * 8 + i - 1] : 1'b1;
        repeat (2) @(negedge ref_clk);
        i2c_scl = 1'b1;
        repeat (2) @(negedge ref_clk);
        if (i == 0) ak[b] = i2c_sda_oe;
        repeat (2) @(negedge ref_clk);
        i2c_scl = 1'b0;
      end
    end
    repeat (2) @(negedge ref_clk);
    i2c_sda_h = 1'b0;
    repeat (4) @(negedge ref_clk);
    i2c_scl = 1'b1;
    repeat (4) @(negedge ref_clk);
    i2c_sda_h = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  // reset with given straps, then settle
  task automatic boot(input logic hm, input logic [1:0] irq);
    pin_mode = hm;
    irq_lvl = irq;
    sys_rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (20) @(negedge ref_clk);
  endtask
  // expected sysclk fields per config id
  function automatic logic [44:0] exp_cfg(input logic hm, input logic [3:0] iid, input logic [3:0] oid,
    input logic [1:0] c);
    return 45'({hm, iid, oid, c, c == 2'h0 || c == 2'h2, c != 2'h3, (c == 2'h2) ? 8'h10 : 8'h08});
  endfunction
  // read-only, unmapped and live registers
  task automatic t_regs;
    rdchk(13'h000B, 8'h0F);
    wr(13'h000B, 8'hAA);
    rdchk(13'h000B, 8'h0F);
    wr(13'h000A, 8'h00);
    rdchk(13'h000A, 8'h3D);
    rdchk(13'h000D, 8'h6B);
    wr(13'h0100, 8'h55);
    rdchk(13'h0100, 8'h00);
    wr(13'h0007, 8'hA5);
    rdchk(13'h0007, 8'hA5);
    i2c_wr(13'h0006, 8'h5A);
    chk_reg({4'h0, ak}, 8'h0F);
    rdchk(13'h0006, 8'h5A);
  endtask
  // soft configuration held until update
  task automatic t_soft;
    chk_out(45'(cfg_vec), exp_cfg(1'b0, 4'h0, 4'h0, 2'h0));
    wr(13'h0C00, 8'h01);
    wr(13'h0C03, 8'h01);
    wr(13'h0C01, 8'h7A);
    wr(13'h0C02, 8'h03);
    wr(13'h0C04, 8'h01);
    wr(13'h0C05, 8'hE4);
    wr(13'h0C06, 8'h1B);
    chk_out(45'(cfg_vec), exp_cfg(1'b0, 4'h0, 4'h0, 2'h0));
    chk_out(tune_vec, TUNE_DEF);
    wr(13'h0005, 8'h01);
    rdchk(13'h0005, 8'h00);
    chk_out(45'(cfg_vec), exp_cfg(1'b0, 4'hA, 4'h7, 2'h3));
    chk_out(tune_vec, {5'h1D, 20'h0_8424, 20'h8_2081});
    rdchk(13'h0C01, 8'h7A);
  endtask
  // soft reset, then writes refused while sections are off
  task automatic t_gate;
    wr(13'h0006, 8'h3C);
    wr(13'h0000, 8'h20);
    rdchk(13'h0006, 8'h00);
    chk_out(tune_vec, TUNE_DEF);
    wr(13'h0C01, 8'h55);
    wr(13'h0C04, 8'hFF);
    wr(13'h0C00, 8'h01);
    wr(13'h0C03, 8'h01);
    wr(13'h0005, 8'h01);
    chk_out(45'(cfg_vec), exp_cfg(1'b0, 4'h0, 4'h0, 2'h0));
    chk_out(tune_vec, TUNE_DEF);
  endtask
  // store load skips port control, buffered readback shows loaded byte
  task automatic t_load;
    wr(13'h0004, 8'h01);
    wr(13'h0005, 8'h01);
    nv_addr = 13'h0000;
    nv_data = 8'h80;
    nv_we = 1'b1;
    @(negedge ref_clk);
    nv_addr = 13'h0C01;
    nv_data = 8'h3B;
    @(negedge ref_clk);
    nv_we = 1'b0;
    rdchk(13'h0C01, 8'h3B);
    rdchk(13'h0000, 8'h00);
    wr(13'h0005, 8'h01);
    chk_out(45'(cfg_vec), exp_cfg(1'b0, 4'hB, 4'h3, 2'h0));
  endtask
  // strap decode for every irq level
  task automatic t_hard;
    for (int i = 0; i < 3; i++) begin
      boot(1'b1, 2'(i));
      chk_out(45'(cfg_vec), exp_cfg(1'b1, 4'hA, 4'h7, 2'(i)));
      chk_out(tune_vec, TUNE_DEF);
    end
    wr(13'h0200, 8'h01);
    wr(13'h0006, 8'hC3);
    i2c_wr(13'h0006, 8'h77);
    chk_reg({4'h0, ak}, 8'h00);
    rdchk(13'h0006, 8'hC3);
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    pin_mode = 1'b0;
    irq_lvl = 2'h1;
    straps = 12'h425;
    nv_we = 1'b0;
    nv_addr = 13'h0000;
    nv_data = 8'h00;
    i2c_scl = 1'b1;
    i2c_sda_h = 1'b1;
    boot(1'b0, 2'h1);
    t_regs;
    t_soft;
    t_gate;
    t_load;
    t_hard;
    summarize;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    summarize;
  end
endmodule
bind pcl_loader pcl_loader_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .i2c_sda_oe(i2c_sda_oe),
  .hard_mode(hard_mode), .input_freq_id(input_freq_id), .output_freq_id(output_freq_id),
  .sysclk_cfg(sysclk_cfg), .crystal_input_mode(crystal_input_mode), .sysclk_doubler_en(sysclk_doubler_en),
  .sysclk_n_div(sysclk_n_div), .ref_scale_factor(ref_scale_factor), .chan_scale_factor(chan_scale_factor));
`default_nettype wire

/* pcl_regs.vh */
// register offsets, field positions, reset values and timing counts of the config loader
`ifndef PCL_REGS_VH
`define PCL_REGS_VH
// register offsets (13-bit serial address)
`define PCL_A_PORT_CTRL 13'h0000
`define PCL_A_RB_CTRL 13'h0004
`define PCL_A_UPDATE 13'h0005
`define PCL_A_SCR_LO 13'h0006
`define PCL_A_SCR_HI 13'h0007
`define PCL_A_SIL_REV 13'h000A
`define PCL_A_RSVD_B 13'h000B
`define PCL_A_FAM_LO 13'h000C
`define PCL_A_FAM_HI 13'h000D
`define PCL_A_S1_EN 13'h0C00
`define PCL_A_FSEL 13'h0C01
`define PCL_A_SCSEL 13'h0C02
`define PCL_A_S2_EN 13'h0C03
`define PCL_A_IN_SCALE 13'h0C04
`define PCL_A_OUT_SCALE 13'h0C05
`define PCL_A_TUNE 13'h0C06
// buffered slot indices
`define PCL_I_RB 3'd0
`define PCL_I_S1 3'd1
`define PCL_I_FSEL 3'd2
`define PCL_I_SCSEL 3'd3
`define PCL_I_S2 3'd4
`define PCL_I_INSC 3'd5
`define PCL_I_OUTSC 3'd6
`define PCL_I_TUNE 3'd7
// field positions
`define PCL_B_SDO_EN 7
`define PCL_B_LSB_FIRST 6
`define PCL_B_SOFT_RST 5
`define PCL_B_UPDATE 0
`define PCL_B_RB_BUF 0
`define PCL_B_SEC_EN 0
`define PCL_B_PM 4
// reset values
`define PCL_RST_BYTE 8'h00
`define PCL_RST_RSVD_B 8'h0F
// three-level pin codes
`define PCL_TL_LOW 2'b00
`define PCL_TL_MID 2'b01
`define PCL_TL_HIGH 2'b10
// system clock divide values
`define PCL_N_DIV8 8'h08
`define PCL_N_DIV16 8'h10
// cycles after reset release before straps are caught
`define PCL_STRAP_SETTLE 2'd3
`endif

/* pcl_spi_host.sv */
// spi host model for the serial port
`timescale 1ns/1ps
`default_nettype none
module pcl_spi_host (
  input wire logic ref_clk, // system clock
  input wire logic spi_sdio_o, // device data
  input wire logic spi_sdio_oe, // device drives
  output logic spi_cs_n, // select
  output logic spi_sclk, // serial clock
  output logic spi_sdio_i // resolved line
);
  logic host_d;
  // resolve the shared data wire
  assign spi_sdio_i = spi_sdio_oe ? spi_sdio_o : host_d;
  // idle: deselected, clock parked low
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    host_d = 1'b0;
  end
  // one 24-bit frame, six cycles per phase
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rq);
    logic [23:0] sh;
    sh = {rd, 2'b00, a, wd};
    rq = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      // whole bytes, reserved bits as given
      host_d = (rd && i < 8) ? ~host_d : sh[i];
      repeat (6) @(negedge ref_clk);
      if (i < 8) rq[i] = spi_sdio_i;
      spi_sclk = 1'b1;
      repeat (6) @(negedge ref_clk);
    end
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    host_d = ~host_d;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire
